// >>> rtl/dual_timer_cascade_pwm.sv
// Dual 8-bit timer, 16-bit cascade, three-channel 10-bit PWM, AHB-Lite slave
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_cascade_pwm
  import dual_timer_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic capture_in_a,
  input wire logic capture_in_b,
  input wire logic ext_count_in_a,
  input wire logic sub_clock_in,
  output logic toggle_out_a,
  output logic toggle_out_b,
  output logic pwm_out_x,
  output logic pwm_out_y,
  output logic pwm_out_z,
  output logic match_a,
  output logic match_b,
  output logic overflow_a,
  output logic overflow_b
);

  typedef struct packed {
    logic [2:0] s_cap_a;
    logic [2:0] s_cap_b;
    logic [2:0] s_ext;
    logic [2:0] s_sub;
    logic [10:0] div;
    logic [7:0] timer_a_control;
    logic [7:0] timer_b_control;
    logic [7:0] timer_a_data;
    logic [7:0] timer_b_data;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [7:0] timer_a_counter;
    logic [7:0] timer_b_counter;
    logic [7:0] pwm_ctrl;
    logic [7:0] pwm_high_bits;
    logic [7:0] duty_low_ch_x;
    logic [7:0] duty_low_ch_y;
    logic [7:0] duty_low_ch_z;
    logic [1:0] misc;
    logic [9:0] pwm_count;
    logic [9:0] act_period;
    logic [29:0] act_duty;
    logic [3:0] sticky;
    logic toggle_out_a;
    logic toggle_out_b;
    logic [2:0] pwm_out;
    logic match_a;
    logic match_b;
    logic overflow_a;
    logic overflow_b;
    logic dp_write;
    logic [9:0] dp_addr;
    logic [31:0] hrdata;
  } state_type;

  state_type st;
  state_type next_st;

  // Tick select for timer A (divide by 1..1024)
  function automatic logic tick_a(input logic [3:0] cs,
      input logic [10:0] d, input logic ext_r, input logic ext_f,
      input logic sub_r);
    logic t;
    t = 1'b0;
    case (cs)
      CS_EXT_RISE: t = ext_r;
      CS_EXT_FALL: t = ext_f;
      CS_SUB: t = sub_r;
      4'h8: t = 1'b1;
      4'h9: t = (d[0] == 1'b1);
      4'hA: t = (d[1:0] == 2'h3);
      4'hB: t = (d[2:0] == 3'h7);
      4'hC: t = (d[3:0] == 4'hF);
      4'hD: t = (d[5:0] == 6'h3F);
      4'hE: t = (d[7:0] == 8'hFF);
      4'hF: t = (d[9:0] == 10'h3FF);
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Tick select for timer B (divide by 2..2048)
  function automatic logic tick_b(input logic [3:0] cs,
      input logic [10:0] d, input logic sub_r);
    logic t;
    t = 1'b0;
    case (cs)
      CS_SUB: t = sub_r;
      4'h8: t = (d[0] == 1'b1);
      4'h9: t = (d[1:0] == 2'h3);
      4'hA: t = (d[2:0] == 3'h7);
      4'hB: t = (d[3:0] == 4'hF);
      4'hC: t = (d[4:0] == 5'h1F);
      4'hD: t = (d[6:0] == 7'h7F);
      4'hE: t = (d[8:0] == 9'h1FF);
      4'hF: t = (d[10:0] == DIV_WIDTH);
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  // Steady or compared PWM level for one channel
  function automatic logic pwm_level(input logic [9:0] cnt,
      input logic [9:0] duty, input logic [9:0] per, input logic pol);
    logic l;
    if (duty == per) begin
      l = pol;
    end else if (duty == 10'h000) begin
      l = ~pol;
    end else begin
      l = (cnt <= duty) ? pol : ~pol;
    end
    return l;
  endfunction

  logic cap_a_ev, cap_b_ev, ext_r, ext_f, sub_r;
  logic ta, tb, mode_a, mode_b, cascade, pwm_on;
  logic [15:0] pair, pair_next;
  logic [7:0] a_next, b_next;
  logic [9:0] per_new;
  logic [29:0] duty_new;

  always_comb begin
    next_st = st;
    // Only the second and third stages are compared
    ext_r = st.s_ext[1] & ~st.s_ext[2];
    ext_f = ~st.s_ext[1] & st.s_ext[2];
    sub_r = st.s_sub[1] & ~st.s_sub[2];
    cascade = st.misc[MISC_CASCADE_BIT];
    cap_a_ev = (cascade && st.misc[MISC_FALLING_BIT]) ?
      (~st.s_cap_a[1] & st.s_cap_a[2]) :
      (st.s_cap_a[1] & ~st.s_cap_a[2]);
    cap_b_ev = st.s_cap_b[1] & ~st.s_cap_b[2];
    mode_a = st.timer_a_control[CTRL_MODE_BIT];
    mode_b = st.timer_b_control[CTRL_MODE_BIT];
    pwm_on = st.pwm_ctrl[PWM_SELECT_BIT];
    ta = tick_a(st.timer_a_control[CTRL_CS_MSB:0], st.div, ext_r, ext_f,
      sub_r);
    tb = tick_b(st.timer_b_control[CTRL_CS_MSB:0], st.div, sub_r);
    pair = {st.timer_b_counter, st.timer_a_counter};
    pair_next = pair + 16'h0001;
    a_next = st.timer_a_counter + 8'h01;
    b_next = st.timer_b_counter + 8'h01;
    per_new = {st.pwm_high_bits[1:0], st.timer_a_data};
    duty_new = {st.pwm_high_bits[7:6], st.duty_low_ch_z,
      st.pwm_high_bits[5:4], st.duty_low_ch_y,
      st.pwm_high_bits[3:2], st.duty_low_ch_x};
    next_st.s_cap_a = {st.s_cap_a[1:0], capture_in_a};
    next_st.s_cap_b = {st.s_cap_b[1:0], capture_in_b};
    next_st.s_ext = {st.s_ext[1:0], ext_count_in_a};
    next_st.s_sub = {st.s_sub[1:0], sub_clock_in};
    next_st.div = st.div + 11'h001;
    next_st.match_a = 1'b0;
    next_st.match_b = 1'b0;
    next_st.overflow_a = 1'b0;
    next_st.overflow_b = 1'b0;
    next_st.timer_a_control[CTRL_CLEAR_BIT] = 1'b0;
    next_st.timer_b_control[CTRL_CLEAR_BIT] = 1'b0;

    if (pwm_on) begin
      // Period end reloads period and duties together
      if (ta) begin
        if (st.pwm_count >= st.act_period) begin
          next_st.pwm_count = 10'h000;
          next_st.act_period = per_new;
          next_st.act_duty = duty_new;
        end else begin
          next_st.pwm_count = st.pwm_count + 10'h001;
        end
      end
      next_st.pwm_out[0] = pwm_level(st.pwm_count, st.act_duty[9:0],
        st.act_period, st.pwm_ctrl[POL_X_BIT]);
      next_st.pwm_out[1] = pwm_level(st.pwm_count, st.act_duty[19:10],
        st.act_period, st.pwm_ctrl[POL_Y_BIT]);
      next_st.pwm_out[2] = pwm_level(st.pwm_count, st.act_duty[29:20],
        st.act_period, st.pwm_ctrl[POL_Z_BIT]);
    end else begin
      next_st.pwm_count = 10'h000;
      next_st.act_period = per_new;
      next_st.act_duty = duty_new;
      if (cascade) begin
        if (mode_a && cap_a_ev) begin
          next_st.timer_a_data = st.timer_a_counter;
          next_st.timer_b_data = st.timer_b_counter;
          next_st.timer_a_counter = RESET_BYTE;
          next_st.timer_b_counter = RESET_BYTE;
        end else if (ta) begin
          if (!mode_a && pair == {st.buf_b, st.buf_a}) begin
            next_st.toggle_out_a = ~st.toggle_out_a;
            next_st.match_a = 1'b1;
            next_st.timer_a_counter = RESET_BYTE;
            next_st.timer_b_counter = RESET_BYTE;
          end else begin
            next_st.timer_a_counter = pair_next[7:0];
            next_st.timer_b_counter = pair_next[15:8];
            if (mode_a && pair == 16'hFFFF) begin
              next_st.overflow_a = 1'b1;
            end
          end
        end
      end else begin
        if (mode_a && cap_a_ev) begin
          next_st.timer_a_data = st.timer_a_counter;
          next_st.timer_a_counter = RESET_BYTE;
        end else if (ta) begin
          if (!mode_a && st.timer_a_counter == st.buf_a) begin
            next_st.toggle_out_a = ~st.toggle_out_a;
            next_st.match_a = 1'b1;
            next_st.timer_a_counter = RESET_BYTE;
          end else begin
            next_st.timer_a_counter = a_next;
            next_st.overflow_a = mode_a && (a_next == RESET_BYTE);
          end
        end
      end
    end

    if (!cascade) begin
      if (mode_b && cap_b_ev) begin
        next_st.timer_b_data = st.timer_b_counter;
        next_st.timer_b_counter = RESET_BYTE;
      end else if (tb) begin
        if (!mode_b && st.timer_b_counter == st.buf_b) begin
          next_st.toggle_out_b = ~st.toggle_out_b;
          next_st.match_b = 1'b1;
          next_st.timer_b_counter = RESET_BYTE;
        end else begin
          next_st.timer_b_counter = b_next;
          next_st.overflow_b = mode_b && (b_next == RESET_BYTE);
        end
      end
    end

    // Sticky event view; a new event wins over a clear
    next_st.sticky = st.sticky;
    if (st.dp_write && st.dp_addr == ADDR_EVENT_STATUS) begin
      next_st.sticky = st.sticky & ~hwdata[3:0];
    end
    next_st.sticky = next_st.sticky | {next_st.overflow_b,
      next_st.overflow_a, next_st.match_b, next_st.match_a};

    // AHB-Lite data phase: zero wait, always OKAY
    if (st.dp_write) begin
      case (st.dp_addr)
        ADDR_TIMER_A_CONTROL: begin
          next_st.timer_a_control = hwdata[7:0];
          if (hwdata[CTRL_CLEAR_BIT]) begin
            next_st.timer_a_counter = RESET_BYTE;
            next_st.buf_a = st.timer_a_data;
            if (cascade) begin
              next_st.timer_b_counter = RESET_BYTE;
              next_st.buf_b = st.timer_b_data;
            end
          end
        end
        ADDR_TIMER_B_CONTROL: begin
          next_st.timer_b_control = hwdata[7:0];
          if (hwdata[CTRL_CLEAR_BIT]) begin
            next_st.timer_b_counter = RESET_BYTE;
            next_st.buf_b = st.timer_b_data;
          end
        end
        ADDR_TIMER_A_DATA: next_st.timer_a_data = hwdata[7:0];
        ADDR_TIMER_B_DATA: next_st.timer_b_data = hwdata[7:0];
        ADDR_DUTY_X: next_st.duty_low_ch_x = hwdata[7:0];
        ADDR_DUTY_Y: next_st.duty_low_ch_y = hwdata[7:0];
        ADDR_DUTY_Z: next_st.duty_low_ch_z = hwdata[7:0];
        ADDR_PWM_CTRL: next_st.pwm_ctrl = {hwdata[7:4], 4'h0};
        ADDR_PWM_HIGH_BITS: next_st.pwm_high_bits = hwdata[7:0];
        ADDR_MISC_CTRL: next_st.misc = hwdata[1:0];
        default: next_st.misc = st.misc;
      endcase
    end

    next_st.dp_write = 1'b0;
    next_st.hrdata = 32'h0000_0000;
    if (hsel && hready && htrans == HTRANS_NONSEQ) begin
      next_st.dp_write = hwrite;
      next_st.dp_addr = haddr[9:0];
      if (!hwrite) begin
        case (haddr[9:0])
          ADDR_TIMER_A_CONTROL: next_st.hrdata[7:0] = st.timer_a_control;
          ADDR_TIMER_B_CONTROL: next_st.hrdata[7:0] = st.timer_b_control;
          ADDR_TIMER_A_DATA: next_st.hrdata[7:0] = st.timer_a_data;
          ADDR_TIMER_B_DATA: next_st.hrdata[7:0] = st.timer_b_data;
          ADDR_TIMER_A_COUNTER: next_st.hrdata[7:0] = st.timer_a_counter;
          ADDR_TIMER_B_COUNTER: next_st.hrdata[7:0] = st.timer_b_counter;
          ADDR_DUTY_X: next_st.hrdata[7:0] = st.duty_low_ch_x;
          ADDR_DUTY_Y: next_st.hrdata[7:0] = st.duty_low_ch_y;
          ADDR_DUTY_Z: next_st.hrdata[7:0] = st.duty_low_ch_z;
          ADDR_PWM_CTRL: next_st.hrdata[7:0] = st.pwm_ctrl;
          ADDR_PWM_HIGH_BITS: next_st.hrdata[7:0] = st.pwm_high_bits;
          ADDR_MISC_CTRL: next_st.hrdata[1:0] = st.misc;
          ADDR_EVENT_STATUS: next_st.hrdata[3:0] = st.sticky;
          default: next_st.hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
      st.timer_a_data <= RESET_PERIOD;
      st.timer_b_data <= RESET_PERIOD;
      st.buf_a <= RESET_PERIOD;
      st.buf_b <= RESET_PERIOD;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata = st.hrdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign toggle_out_a = st.toggle_out_a;
  assign toggle_out_b = st.toggle_out_b;
  assign pwm_out_x = st.pwm_out[0];
  assign pwm_out_y = st.pwm_out[1];
  assign pwm_out_z = st.pwm_out[2];
  assign match_a = st.match_a;
  assign match_b = st.match_b;
  assign overflow_a = st.overflow_a;
  assign overflow_b = st.overflow_b;

  chk_match_a_toggle: assert property (@(posedge clock) disable iff (!arst_n)
    st.match_a |-> st.toggle_out_a != $past(st.toggle_out_a))
    else $error("match A without toggle");
  chk_match_a_clear: assert property (@(posedge clock) disable iff (!arst_n)
    st.match_a |-> st.timer_a_counter == 8'h00)
    else $error("match A did not clear counter");
  chk_match_b_toggle: assert property (@(posedge clock) disable iff (!arst_n)
    st.match_b |-> st.toggle_out_b != $past(st.toggle_out_b))
    else $error("match B without toggle");
  chk_ovf_a_wrap: assert property (@(posedge clock) disable iff (!arst_n)
    st.overflow_a |-> st.timer_a_counter == 8'h00)
    else $error("overflow A without wrap");
  chk_ovf_b_wrap: assert property (@(posedge clock) disable iff (!arst_n)
    st.overflow_b |-> st.timer_b_counter == 8'h00 &&
    !$past(st.misc[MISC_CASCADE_BIT]))
    else $error("overflow B without wrap");
  chk_clear_self: assert property (@(posedge clock) disable iff (!arst_n)
    st.timer_a_control[4] |=> !st.timer_a_control[4])
    else $error("clear bit stuck");
  chk_pwm_idle: assert property (@(posedge clock) disable iff (!arst_n)
    !st.pwm_ctrl[4] |=> st.pwm_count == 10'h000)
    else $error("PWM counter runs while off");
  chk_stop_hold: assert property (@(posedge clock) disable iff (!arst_n)
    st.timer_b_control[3:0] == 4'h0 && !st.dp_write && !st.misc[0] &&
    !st.timer_b_control[5] |=> $stable(st.timer_b_counter))
    else $error("stopped counter moved");

endmodule
`default_nettype wire

// >>> rtl/dual_timer_pkg.sv
// Constants for the dual 8-bit timer with cascade and PWM
package dual_timer_pkg;
  // Register byte addresses (word aligned on the bus)
  localparam logic [9:0] ADDR_TIMER_A_CONTROL = 10'h000;
  localparam logic [9:0] ADDR_TIMER_B_CONTROL = 10'h004;
  localparam logic [9:0] ADDR_TIMER_A_DATA = 10'h008;
  localparam logic [9:0] ADDR_TIMER_B_DATA = 10'h00C;
  localparam logic [9:0] ADDR_TIMER_A_COUNTER = 10'h010;
  localparam logic [9:0] ADDR_TIMER_B_COUNTER = 10'h014;
  localparam logic [9:0] ADDR_DUTY_X = 10'h018;
  localparam logic [9:0] ADDR_DUTY_Y = 10'h01C;
  localparam logic [9:0] ADDR_DUTY_Z = 10'h020;
  // Numbered registers are word indices; byte address is four times it
  localparam logic [7:0] PWM_CTRL_INDEX = 8'hCE;
  localparam logic [7:0] PWM_HIGH_BITS_INDEX = 8'hCF;
  localparam logic [9:0] ADDR_PWM_CTRL = {PWM_CTRL_INDEX, 2'h0};
  localparam logic [9:0] ADDR_PWM_HIGH_BITS = {PWM_HIGH_BITS_INDEX, 2'h0};
  localparam logic [9:0] ADDR_MISC_CTRL = 10'h024;
  localparam logic [9:0] ADDR_EVENT_STATUS = 10'h028;
  // Control field positions
  localparam int CTRL_MODE_BIT = 5;
  localparam int CTRL_CLEAR_BIT = 4;
  localparam int CTRL_CS_MSB = 3;
  localparam int PWM_SELECT_BIT = 4;
  localparam int POL_X_BIT = 5;
  localparam int POL_Y_BIT = 6;
  localparam int POL_Z_BIT = 7;
  localparam int MISC_CASCADE_BIT = 0;
  localparam int MISC_FALLING_BIT = 1;
  // Clock select codes
  localparam logic [3:0] CS_STOP = 4'h0;
  localparam logic [3:0] CS_EXT_RISE = 4'h5;
  localparam logic [3:0] CS_EXT_FALL = 4'h6;
  localparam logic [3:0] CS_SUB = 4'h7;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] RESET_PERIOD = 8'hFF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [10:0] DIV_WIDTH = 11'h7FF;
endpackage

// >>> verification/dual_timer_cascade_pwm_tb.sv
// Self-checking bench for the dual timer with cascade and PWM
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module dual_timer_cascade_pwm_tb
  import dual_timer_pkg::*;
();
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic capture_in_a = 1'b0;
  logic capture_in_b = 1'b0;
  logic ext_count_in_a = 1'b0;
  logic sub_clock_in = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, toggle_out_a, toggle_out_b;
  logic pwm_out_x, pwm_out_y, pwm_out_z;
  logic match_a, match_b, overflow_a, overflow_b;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int cnt [5];
  // Clocks per tick for each select code; pins and sub clock follow cyc
  int div_a [16] = '{0, 0, 0, 0, 0, 20, 20, 16,
                     1, 2, 4, 8, 16, 64, 256, 1024};
  int div_b [16] = '{0, 0, 0, 0, 0, 0, 0, 16,
                     2, 4, 8, 16, 32, 128, 512, 2048};

  dual_timer_cascade_pwm u_dut (
    .clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .capture_in_a(capture_in_a),
    .capture_in_b(capture_in_b), .ext_count_in_a(ext_count_in_a),
    .sub_clock_in(sub_clock_in), .toggle_out_a(toggle_out_a),
    .toggle_out_b(toggle_out_b), .pwm_out_x(pwm_out_x),
    .pwm_out_y(pwm_out_y), .pwm_out_z(pwm_out_z), .match_a(match_a),
    .match_b(match_b), .overflow_a(overflow_a), .overflow_b(overflow_b)
  );

  initial begin
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc % 8 == 7) begin
      sub_clock_in <= ~sub_clock_in;
    end
    if (cyc % 10 == 9) begin
      ext_count_in_a <= ~ext_count_in_a;
    end
  end

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic timeout(input string nm);
    bad_count++;
    $display("unexpected %s expected event seen none", nm);
    end_of_test();
  endtask

  task automatic ready_wait;
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) timeout("hready");
  endtask

  // Address phase held until hready, then data phase until hready again
  task automatic bus(input logic w, input logic [9:0] a,
                     input logic [31:0] wd, output logic [31:0] rdata);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {22'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    ready_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    ready_wait();
    rdata = hrdata;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] x;
    bus(1'b1, a, {24'h0, d}, x);
  endtask

  task automatic rd(input logic [9:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h0, v);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return match_a;
      1: return match_b;
      2: return overflow_a;
      default: return overflow_b;
    endcase
  endfunction

  // Clocks from one pulse to the next on the chosen event output
  task automatic gap(input int w, output int n);
    int k;
    k = 0;
    n = 0;
    // Pulses launched under the previous setting are still in flight
    repeat (2) @(posedge clock);
    while (pick(w) !== 1'b1 && k < 9000) begin
      @(posedge clock);
      k++;
    end
    do begin
      @(posedge clock);
      n++;
    end while (pick(w) !== 1'b1 && n < 9000);
    if (k >= 9000 || n >= 9000) timeout("event pulse");
  endtask

  task automatic watch(input int cycles);
    logic pa;
    logic pb;
    cnt = '{default: 0};
    pa = toggle_out_a;
    pb = toggle_out_b;
    repeat (cycles) begin
      @(posedge clock);
      cnt[0] += int'(pwm_out_x === 1'b1);
      cnt[1] += int'(pwm_out_y === 1'b1);
      cnt[2] += int'(pwm_out_z === 1'b1);
      cnt[3] += int'(toggle_out_a !== pa);
      cnt[4] += int'(toggle_out_b !== pb);
      pa = toggle_out_a;
      pb = toggle_out_b;
    end
  endtask

  task automatic t_regs;
    logic [31:0] v;
    rd(ADDR_PWM_CTRL, v);
    `CHK("pwm ctrl reset", 32'h0, v);
    `CHK("okay response", 1'b0, hresp);
    rd(10'h080, v);
    `CHK("unmapped read", 32'h0, v);
    rd(ADDR_TIMER_A_DATA, v);
    `CHK("timer a data reset", 32'hFF, v);
    wr(ADDR_PWM_HIGH_BITS, 8'h15);
    rd(ADDR_PWM_HIGH_BITS, v);
    `CHK("high bits readback", 32'h15, v);
  endtask

  task automatic t_interval;
    logic [31:0] v;
    int n;
    wr(ADDR_TIMER_A_DATA, 8'h05);
    wr(ADDR_TIMER_B_DATA, 8'h03);
    wr(ADDR_TIMER_A_CONTROL, 8'h18);
    wr(ADDR_TIMER_B_CONTROL, 8'h18);
    gap(0, n);
    `CHK("timer a match gap", 6, n);
    gap(1, n);
    `CHK("timer b match gap", 8, n);
    watch(240);
    `CHK("toggles on out a", 40, cnt[3]);
    `CHK("toggles on out b", 30, cnt[4]);
    `CHK("pwm x in timer mode", 0, cnt[0]);
    rd(ADDR_EVENT_STATUS, v);
    `CHK("event status", 32'h3, v);
  endtask

  task automatic t_clock;
    int n;
    wr(ADDR_TIMER_A_DATA, 8'h01);
    wr(ADDR_TIMER_B_DATA, 8'h01);
    for (int c = 5; c < 16; c++) begin
      wr(ADDR_TIMER_A_CONTROL, 8'h10 | 8'(c));
      gap(0, n);
      `CHK("timer a tick gap", 2 * div_a[c], n);
      if (div_b[c] != 0) begin
        wr(ADDR_TIMER_B_CONTROL, 8'h10 | 8'(c));
        gap(1, n);
        `CHK("timer b tick gap", 2 * div_b[c], n);
      end
    end
  endtask

  task automatic t_stop;
    logic [31:0] v1;
    logic [31:0] v2;
    wr(ADDR_TIMER_A_DATA, 8'hFF);
    wr(ADDR_TIMER_A_CONTROL, 8'h18);
    repeat (10) @(posedge clock);
    wr(ADDR_TIMER_A_CONTROL, {4'h0, CS_STOP});
    rd(ADDR_TIMER_A_COUNTER, v1);
    `CHK("counter ran before stop", 1'b1, v1 != 0);
    repeat (30) @(posedge clock);
    rd(ADDR_TIMER_A_COUNTER, v2);
    `CHK("stopped counter", v1, v2);
  endtask

  // Capture windows allow for pin synchronisers and bus cycles
  task automatic t_capture;
    logic [31:0] v;
    int n;
    wr(ADDR_TIMER_A_CONTROL, 8'h38);
    wr(ADDR_TIMER_B_CONTROL, 8'h38);
    repeat (100) @(posedge clock);
    capture_in_a <= 1'b1;
    capture_in_b <= 1'b1;
    repeat (4) @(posedge clock);
    capture_in_a <= 1'b0;
    capture_in_b <= 1'b0;
    repeat (12) @(posedge clock);
    rd(ADDR_TIMER_A_DATA, v);
    `CHK("capture a in window", 1'b1, v >= 100 && v <= 120);
    rd(ADDR_TIMER_B_DATA, v);
    `CHK("capture b in window", 1'b1, v >= 48 && v <= 62);
    rd(ADDR_TIMER_A_COUNTER, v);
    `CHK("counter a cleared", 1'b1, v < 30);
    gap(2, n);
    `CHK("overflow gap", 256, n);
    gap(3, n);
    `CHK("overflow b gap", 512, n);
  endtask

  task automatic t_cascade;
    logic [31:0] lo;
    logic [31:0] hi;
    int n;
    wr(ADDR_MISC_CTRL, 8'h01);
    wr(ADDR_TIMER_A_DATA, 8'h03);
    wr(ADDR_TIMER_B_DATA, 8'h01);
    wr(ADDR_TIMER_A_CONTROL, 8'h18);
    gap(0, n);
    `CHK("cascade match gap", 260, n);
    watch(520);
    `CHK("cascade toggles", 2, cnt[3]);
    wr(ADDR_MISC_CTRL, 8'h03);
    wr(ADDR_TIMER_A_CONTROL, 8'h38);
    repeat (300) @(posedge clock);
    capture_in_a <= 1'b1;
    repeat (40) @(posedge clock);
    capture_in_a <= 1'b0;
    repeat (12) @(posedge clock);
    rd(ADDR_TIMER_A_DATA, lo);
    rd(ADDR_TIMER_B_DATA, hi);
    n = int'({hi[7:0], lo[7:0]});
    `CHK("falling capture", 1'b1, n >= 335 && n <= 365);
    rd(ADDR_TIMER_B_COUNTER, hi);
    `CHK("high counter cleared", 32'h0, hi);
  endtask

  // Period 0x104, duty x 0x100 high, y equal period low, z zero
  task automatic t_pwm;
    wr(ADDR_MISC_CTRL, 8'h00);
    wr(ADDR_TIMER_A_CONTROL, 8'h10);
    wr(ADDR_TIMER_A_DATA, 8'h04);
    wr(ADDR_PWM_HIGH_BITS, 8'h15);
    wr(ADDR_DUTY_X, 8'h00);
    wr(ADDR_DUTY_Y, 8'h04);
    wr(ADDR_DUTY_Z, 8'h00);
    wr(ADDR_PWM_CTRL, 8'h30);
    wr(ADDR_TIMER_A_CONTROL, 8'h18);
    repeat (600) @(posedge clock);
    watch(522);
    `CHK("pwm x active", 514, cnt[0]);
    `CHK("pwm y full duty", 0, cnt[1]);
    `CHK("pwm z zero duty", 522, cnt[2]);
    wr(ADDR_TIMER_A_DATA, 8'h20);
    repeat (700) @(posedge clock);
    watch(578);
    `CHK("duty kept on new period", 514, cnt[0]);
    `CHK("pwm y low polarity", 56, cnt[1]);
    `CHK("pwm z still high", 578, cnt[2]);
  endtask

  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    t_regs();
    t_interval();
    t_clock();
    t_stop();
    t_capture();
    t_cascade();
    t_pwm();
    end_of_test();
  end
endmodule
`default_nettype wire
